/* File: logic/power_mode_control.sv */
// Operating power mode control: main and low-speed select registers
// Assumes a single-cycle strobe register port on CORE_CLK, and status
// levels for unlock, sleep, deep sleep and flash work from other clocks
//
// Summary of operation
// (R1) Mode bits 2..0: 000 high, 010 middle
// (R2) Bit 3 of main register reads zero
// (R3) Main busy flag sets on write, clears after
// (R4) Writes need the system unlock bit set
// (R5) Main register locked while its busy flag
// (R6) Both registers locked during sleep entry/exit
// (R7) Both registers locked during deep sleep
// (R8) Main register locked while low-speed enabled
// (R9) Both registers locked during flash program/erase
// (R10) Software rewrites mode only when flag clear
// (R11) Low-speed bit one enters, zero returns
// (R12) Low-speed busy flag on select rewrite
// (R13) Low-speed register locked while its busy
// (R14) Reserved bits read back zero
// (R15) Reset starts in high-speed mode
// (R16) Low-speed only on sub-clock oscillator
// (R17) Software keeps read clocks within limits
// (R18) Flash clock 1 to 32 MHz for programming
// (R19) Below 4 MHz use 1, 2 or 3 MHz
// (R20) No system writes during sleep or transitions
// (R21) Blocked writes change nothing
// (R22) Busy flags clear after settling, never instantly
//
// The address-and-strobe port was left to the implementer.
`include "power_mode_params.svh"
module power_mode_control #(
    parameter int SETTLE_CYCLES = `PM_SETTLE_CYCLES
) (
    input  wire logic                      CORE_CLK,
    input  wire logic                      RST_N,
    input  wire logic [`PM_ADDR_WIDTH-1:0] ADDR,
    input  wire logic [7:0]                WDATA,
    input  wire logic                      WR,
    input  wire logic                      RD,
    output logic      [7:0]                RDATA,
    input  wire logic                      SYSTEM_WRITE_UNLOCK_BIT,
    input  wire logic                      SLEEP_ACTIVE,
    input  wire logic                      DEEP_SLEEP_ACTIVE,
    input  wire logic                      FLASH_PE_ACTIVE,
    output logic      [2:0]                MAIN_MODE_FIELD,
    output logic                           LOW_SPEED_ENABLE_BIT,
    output logic      [1:0]                POWER_MODE,
    output logic                           MODE_BUSY
);
    logic       rst_meta;
    logic       rst_n;
    localparam int STATUS_COUNT = 4;

    // Synchronised status levels
    logic [STATUS_COUNT-1:0] status_pin;
    logic [STATUS_COUNT-1:0] status;
    logic                    unlock;
    logic                    sleep;
    logic                    deep;
    logic                    flash;

    // Register state and write decode
    logic [2:0] main_mode;
    logic       low_en;
    logic       main_busy;
    logic       low_busy;
    logic       main_start;
    logic       low_start;
    logic       common_block;
    logic [2:0] next_main_mode;
    logic       next_low_en;
    logic [7:0] next_rdata;
    logic [1:0] next_power_mode;
    logic       next_mode_busy;
    power_mode_pkg::power_mode_type mode_now;

    // Refuse settings the counters or the byte read path cannot serve
    if (SETTLE_CYCLES < 1) begin : g_bad_settle
        $error("SETTLE_CYCLES must be at least one");
    end
    if (`PM_BUSY_BIT > 7 || `PM_MODE_MSB > 7) begin : g_bad_field
        $error("Register fields must lie inside one byte");
    end
    if (`PM_MODE_MSB - `PM_MODE_LSB != 2) begin : g_bad_mode_width
        $error("Mode field must be three bits wide");
    end
    if (`PM_OFFSET_MAIN == `PM_OFFSET_LOW) begin : g_bad_offsets
        $error("The two register offsets must differ");
    end

    function automatic logic hit(input logic [`PM_ADDR_WIDTH-1:0] a,
                                 input logic [`PM_ADDR_WIDTH-1:0] off);
        return a == off;
    endfunction

    // Low speed wins once its own settling is over; any code other
    // than middle falls back to high speed
    function automatic power_mode_pkg::power_mode_type effective_mode(
        input logic [2:0] field,
        input logic       low,
        input logic       low_settling
    );
        if (low && !low_settling) begin
            return power_mode_pkg::MODE_LOW;
        end
        if (field == `PM_MODE_MIDDLE) begin
            return power_mode_pkg::MODE_MIDDLE;
        end
        return power_mode_pkg::MODE_HIGH;
    endfunction

    // Reset release through two flops
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Status levels come from other domains; a change counts once
    // the second and third stages agree, so a one-cycle glitch is lost
    assign status_pin = {SYSTEM_WRITE_UNLOCK_BIT, SLEEP_ACTIVE,
                         DEEP_SLEEP_ACTIVE, FLASH_PE_ACTIVE};

    for (genvar i = 0; i < STATUS_COUNT; i++) begin : g_status_sync
        logic [2:0] stage;
        logic [2:0] next_stage;
        logic       level;
        logic       next_level;

        always_comb begin
            next_stage = {stage[1:0], status_pin[i]};
            next_level = (stage[1] == stage[2]) ? stage[2] : level;
        end

        always_ff @(posedge CORE_CLK or negedge rst_n) begin
            if (!rst_n) begin
                stage <= 3'h0;
                level <= 1'b0;
            end else begin
                stage <= next_stage;
                level <= next_level;
            end
        end

        assign status[i] = level;
    end

    assign unlock = status[3];
    assign sleep  = status[2];
    assign deep   = status[1];
    assign flash  = status[0];

    // Blocking terms shared by both registers
    always_comb begin
        common_block = !unlock // R4
                     || sleep // R6
                     || deep // R7
                     || flash; // R9
        main_start = WR && hit(ADDR, `PM_OFFSET_MAIN) && !common_block
                   && !main_busy // R5
                   && !low_en; // R8
        low_start  = WR && hit(ADDR, `PM_OFFSET_LOW) && !common_block
                   && !low_busy; // R13
    end

    // Stored mode field; a refused write falls through untouched
    always_comb begin
        next_main_mode = main_mode; // R21
        if (main_start) begin
            next_main_mode = WDATA[`PM_MODE_MSB:`PM_MODE_LSB]; // R1
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            main_mode <= `PM_MODE_HIGH; // R15
        end else begin
            main_mode <= next_main_mode;
        end
    end

    // Low-speed select; clearing it hands control back to the field
    always_comb begin
        next_low_en = low_en; // R21
        if (low_start) begin
            next_low_en = WDATA[`PM_LOW_BIT]; // R11
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            low_en <= 1'b0;
        end else begin
            low_en <= next_low_en;
        end
    end

    // Main mode only takes effect once its settling ends, so the
    // reported mode lags the register by the busy time
    always_comb begin
        mode_now = effective_mode(main_mode, low_en, low_busy); // R11
        next_power_mode = (main_busy || low_busy) ? POWER_MODE
                                                  : 2'(mode_now);
        next_mode_busy  = main_busy || low_busy;
    end

    // Read data valid only in the cycle after the strobe
    always_comb begin
        next_rdata = 8'h00; // R14
        if (RD && hit(ADDR, `PM_OFFSET_MAIN)) begin
            next_rdata[`PM_MODE_MSB:`PM_MODE_LSB] = main_mode; // R2
            next_rdata[`PM_BUSY_BIT] = main_busy; // R3
        end else if (RD && hit(ADDR, `PM_OFFSET_LOW)) begin
            next_rdata[`PM_LOW_BIT]  = low_en;
            next_rdata[`PM_BUSY_BIT] = low_busy; // R12
        end
    end

    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            RDATA <= 8'h00;
        end else begin
            RDATA <= next_rdata;
        end
    end

    // Field and select pins load with the state, so they never lag it; MODE_BUSY lags the busy flags by a cycle
    always_ff @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            MAIN_MODE_FIELD      <= `PM_MODE_HIGH;
            LOW_SPEED_ENABLE_BIT <= 1'b0;
            POWER_MODE           <= 2'(power_mode_pkg::MODE_HIGH); // R15
            MODE_BUSY            <= 1'b0;
        end else begin
            MAIN_MODE_FIELD      <= next_main_mode;
            LOW_SPEED_ENABLE_BIT <= next_low_en;
            POWER_MODE           <= next_power_mode;
            MODE_BUSY            <= next_mode_busy;
        end
    end

    // One sequencer per flag
    mode_settle_timer #(
        .CYCLES (SETTLE_CYCLES)
    ) main_timer (
        .clk   (CORE_CLK),
        .rst_n (rst_n),
        .start (main_start), // R3
        .busy  (main_busy)
    );

    mode_settle_timer #(
        .CYCLES (SETTLE_CYCLES)
    ) low_timer (
        .clk   (CORE_CLK),
        .rst_n (rst_n),
        .start (low_start), // R12
        .busy  (low_busy)
    );
endmodule

/* File: include/power_mode_params.svh */
// Constants of the operating power mode control block
// Assumes inclusion by bare name from every file that needs them
`ifndef POWER_MODE_PARAMS_SVH
`define POWER_MODE_PARAMS_SVH
`define PM_ADDR_WIDTH        20
`define PM_OFFSET_MAIN       20'h8_00a0
`define PM_OFFSET_LOW        20'h8_00aa
`define PM_MODE_HIGH         3'h0
`define PM_MODE_MIDDLE       3'h2
`define PM_MODE_LSB          0
`define PM_MODE_MSB          2
`define PM_LOW_BIT           0
`define PM_BUSY_BIT          4
`define PM_SETTLE_NS         200
`define PM_CLOCK_MHZ         100
`define PM_SETTLE_CYCLES     ((`PM_SETTLE_NS * `PM_CLOCK_MHZ) / 1000)
`endif

/* File: include/power_mode_pkg.sv */
// Types of the operating power mode control block
// Assumes no other package
package power_mode_pkg;
    typedef enum logic [1:0] {
        MODE_HIGH,
        MODE_MIDDLE,
        MODE_LOW
    } power_mode_type;
endpackage

/* File: logic/mode_settle_timer.sv */
// Settling sequencer behind one transition busy flag
// Assumes start is a one-cycle pulse on the block clock
module mode_settle_timer #(
    parameter int CYCLES = 20
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic start,
    output logic      busy
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic          next_busy;

    // A zero count would leave busy stuck high
    if (CYCLES < 1) begin : g_bad_cycles
        $error("CYCLES must be at least one");
    end

    always_comb begin
        next_count = count;
        next_busy  = busy;
        if (start) begin
            next_count = CW'(CYCLES);
            next_busy  = 1'b1;
        end else if (busy) begin
            // Busy never clears in the cycle of its trigger
            if (count == CW'(1)) begin // R22
                next_busy = 1'b0;
            end
            next_count = count - CW'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            busy  <= 1'b0;
        end else begin
            count <= next_count;
            busy  <= next_busy;
        end
    end
endmodule

/* File: verif/power_mode_control_chk.sv */
// Assertions on the ports of the power mode control block
// Assumes binding into power_mode_control, one clock domain
`include "power_mode_params.svh"
module power_mode_control_chk #(
    parameter int SETTLE_CYCLES = 20
) (
    input wire logic        CORE_CLK,
    input wire logic        RST_N,
    input wire logic [19:0] ADDR,
    input wire logic        RD,
    input wire logic [7:0]  RDATA,
    input wire logic        SYSTEM_WRITE_UNLOCK_BIT,
    input wire logic        SLEEP_ACTIVE,
    input wire logic        DEEP_SLEEP_ACTIVE,
    input wire logic        FLASH_PE_ACTIVE,
    input wire logic [2:0]  MAIN_MODE_FIELD,
    input wire logic        LOW_SPEED_ENABLE_BIT,
    input wire logic [1:0]  POWER_MODE,
    input wire logic        MODE_BUSY
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    chk_read_idle: assert property (
        !$past(RD) |-> RDATA == 8'h00) else $error("read data outside answer");
    chk_reserved_zero: assert property (
        $past(RD) |-> RDATA[7:5] == 3'h0 && RDATA[3] == 1'h0)
        else $error("reserved bits not zero");
    chk_low_reserved: assert property (
        $past(RD) && $past(ADDR) == `PM_OFFSET_LOW |-> RDATA[3:1] == 3'h0)
        else $error("low register reserved bits not zero");
    chk_low_locks_main: assert property (
        LOW_SPEED_ENABLE_BIT && $past(LOW_SPEED_ENABLE_BIT)
        |=> $stable(MAIN_MODE_FIELD)) else $error("mode changed in low speed");
    chk_busy_holds: assert property (
        $rose(MODE_BUSY) |=> MODE_BUSY) else $error("busy cleared at once");
    chk_busy_ends: assert property (
        $rose(MODE_BUSY) |-> ##[1:60] !MODE_BUSY) else $error("busy stuck");
    chk_mode_waits: assert property (
        $changed(POWER_MODE) |-> !MODE_BUSY) else $error("mode moved while busy");
    chk_unlock_needed: assert property (
        !SYSTEM_WRITE_UNLOCK_BIT [*8]
        |=> $stable({MAIN_MODE_FIELD, LOW_SPEED_ENABLE_BIT}))
        else $error("write taken while locked");
    chk_status_locks: assert property (
        (SLEEP_ACTIVE || DEEP_SLEEP_ACTIVE || FLASH_PE_ACTIVE) [*8]
        |=> $stable({MAIN_MODE_FIELD, LOW_SPEED_ENABLE_BIT}))
        else $error("write taken in sleep or flash work");
endmodule
bind power_mode_control power_mode_control_chk #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
) u_power_mode_control_chk (.CORE_CLK, .RST_N, .ADDR, .RD, .RDATA,
    .SYSTEM_WRITE_UNLOCK_BIT, .SLEEP_ACTIVE, .DEEP_SLEEP_ACTIVE,
    .FLASH_PE_ACTIVE, .MAIN_MODE_FIELD, .LOW_SPEED_ENABLE_BIT, .POWER_MODE,
    .MODE_BUSY);

/* File: verif/cpu_bus_model.sv */
// Register bus master standing in for software on the CPU
// Assumes its tasks are entered just after a rising clock edge
module cpu_bus_model (
    input  wire logic        clk,
    input  wire logic [7:0]  rdata,
    output logic      [19:0] addr,
    output logic      [7:0]  wdata,
    output logic             wr,
    output logic             rd
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        addr = 20'h0_0000;
        wdata = 8'h00;
        wr = 1'h0;
        rd = 1'h0;
    end
    // Strobe drops on the edge; callers leave a gap before the next write
    task automatic write(input logic [19:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'h1;
        @(posedge clk);
        wr    <= 1'h0;
    endtask
    task automatic read(input logic [19:0] a, output logic [7:0] d);
        addr <= a;
        rd   <= 1'h1;
        @(posedge clk);
        rd   <= 1'h0;
        @(posedge clk);
        d = rdata;
    endtask
endmodule

/* File: verif/tb_power_mode_control.sv */
// Self-checking bench of the power mode control block
// Assumes cpu_bus_model and the bound checker are compiled before it
`include "power_mode_params.svh"
module tb_power_mode_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [19:0] M = `PM_OFFSET_MAIN;
    localparam logic [19:0] L = `PM_OFFSET_LOW;
    typedef struct packed {
        logic [3:0] st;
        logic [19:0] a;
        logic [7:0] d;
        logic [7:0] rd;
        logic [1:0] pm;
    } row_type;
    // Status nibble: unlock, sleep, deep sleep, flash work
    row_type rows [10] = '{
        '{4'h0, M, 8'h02, 8'h00, 2'h0},
        '{4'h8, M, 8'hfa, 8'h12, 2'h1},
        '{4'hc, M, 8'h00, 8'h02, 2'h1},
        '{4'ha, L, 8'h01, 8'h00, 2'h1},
        '{4'h9, L, 8'h01, 8'h00, 2'h1},
        '{4'h8, L, 8'hff, 8'h11, 2'h2},
        '{4'h8, M, 8'h00, 8'h02, 2'h2},
        '{4'h8, L, 8'h00, 8'h10, 2'h1},
        '{4'h8, M, 8'h00, 8'h10, 2'h0},
        '{4'h8, 20'h8_00a1, 8'hff, 8'h00, 2'h0}
    };
    logic        clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        unl = 1'h0;
    logic        slp = 1'h0;
    logic        dsl = 1'h0;
    logic        fpe = 1'h0;
    logic [19:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [7:0]  rd_val;
    logic        wr;
    logic        rd;
    logic        busy;
    logic [1:0]  pmode;
    logic [2:0]  mfield;
    logic        lsel;
    int          bad_count = 0;
    int          cmp_count = 0;
    power_mode_control #(.SETTLE_CYCLES(2)) u_power_mode_control (
        .CORE_CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .SYSTEM_WRITE_UNLOCK_BIT(unl),
        .SLEEP_ACTIVE(slp), .DEEP_SLEEP_ACTIVE(dsl), .FLASH_PE_ACTIVE(fpe),
        .MAIN_MODE_FIELD(mfield), .LOW_SPEED_ENABLE_BIT(lsel),
        .POWER_MODE(pmode), .MODE_BUSY(busy));
    cpu_bus_model u_cpu_bus_model (.clk(clk), .rdata(rdata), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd));
    always #5 clk = ~clk;
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Polls the busy flag as software must, bounded
    task automatic settle();
        int n;
        n = 0;
        @(posedge clk);
        while (busy !== 1'h0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        if (n == 100) begin
            bad_count++;
            $display("Error busy wait ran out");
            finish_test();
        end
        @(posedge clk);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk);
        check("reset mode", 8'h00, {6'h00, pmode});
        foreach (rows[i]) begin
            {unl, slp, dsl, fpe} <= rows[i].st;
            repeat (6) @(posedge clk);
            u_cpu_bus_model.write(rows[i].a, rows[i].d);
            u_cpu_bus_model.read(rows[i].a, rd_val);
            check("read back", rows[i].rd, rd_val);
            settle();
            check("power mode", {6'h00, rows[i].pm}, {6'h00, pmode});
        end
        u_cpu_bus_model.write(M, 8'h02);
        @(posedge clk);
        u_cpu_bus_model.write(M, 8'h00);
        u_cpu_bus_model.read(M, rd_val);
        check("write while busy", 8'h02, rd_val);
        settle();
        check("mode field", 8'h02, {5'h00, mfield});
        check("low select", 8'h00, {7'h00, lsel});
        check("middle mode", 8'h01, {6'h00, pmode});
        // Reset again in mid-run: state must fall back to high speed
        rst_n <= 1'h0;
        @(posedge clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge clk);
        check("reset mode", 8'h00, {6'h00, pmode});
        check("reset field", 8'h00, {5'h00, mfield});
        u_cpu_bus_model.read(M, rd_val);
        check("reset read", 8'h00, rd_val);
        finish_test();
    end
endmodule
